// *** tb/cca_asserts.sv ***
`timescale 1ns/1ps
module capture_compare_asserts (
   input wire logic CLK_SYS,
   input wire logic RSTN,
   input wire logic [7:0] SFR_ADDR,
   input wire logic SFR_WR,
   input wire logic SFR_RD,
   input wire capture_compare_pkg::byte_type SFR_RDATA,
   input wire logic TIMEBASE_RUN,
   input wire logic TIMEBASE_TICK,
   input wire logic ARRAY_IRQ_ENABLE,
   input wire logic [3:0] CHANNEL_PIN_OUT,
   input wire logic [3:0] CHANNEL_PIN_OE,
   input wire logic TIMEBASE_CLEAR,
   input wire logic IRQ_REQUEST
);
   import capture_compare_pkg::*;
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (!RSTN);
   // Each output tied to the input that may move it
   AST_RDATA_HOLD: assert property (!$past(SFR_RD) |-> $stable(SFR_RDATA))
      else $error("read data moved without a read");
   AST_UNMAPPED: assert property ($past(SFR_RD) && ($past(SFR_ADDR) < ADDR_INDEX
      || $past(SFR_ADDR) > ADDR_FLAGS) |-> SFR_RDATA == 8'h00) else $error("unmapped read");
   AST_INDEX_UPPER: assert property ($past(SFR_RD) && $past(SFR_ADDR) == ADDR_INDEX
      |-> SFR_RDATA[7:2] == 6'h00) else $error("index upper bits not zero");
   AST_IRQ_GATE: assert property (!$past(ARRAY_IRQ_ENABLE) |-> !IRQ_REQUEST)
      else $error("interrupt with array enable low");
   AST_CLEAR_RUN: assert property (TIMEBASE_CLEAR |-> $past(TIMEBASE_RUN))
      else $error("timer clear while stopped");
   AST_PIN_TICK: assert property ($changed(CHANNEL_PIN_OUT) |-> $past(TIMEBASE_TICK)
      && $past(TIMEBASE_RUN)) else $error("pin toggled without a tick");
   AST_TOGGLE_OE: assert property ($changed(CHANNEL_PIN_OUT) |->
      (($past(CHANNEL_PIN_OUT) ^ CHANNEL_PIN_OUT) & ~$past(CHANNEL_PIN_OE)) == 4'h0)
      else $error("capture channel pin toggled");
   AST_OE_WRITE: assert property ($changed(CHANNEL_PIN_OE) |-> $past(SFR_WR)
      || $past(SFR_WR, 2)) else $error("output enable moved without a write");
   // Main scenarios reached
   cover property ($rose(IRQ_REQUEST));
   cover property (TIMEBASE_CLEAR);
   cover property ($changed(CHANNEL_PIN_OUT));
endmodule

bind capture_compare_array capture_compare_asserts chk_i (
   .CLK_SYS(CLK_SYS),
   .RSTN(RSTN),
   .SFR_ADDR(SFR_ADDR),
   .SFR_WR(SFR_WR),
   .SFR_RD(SFR_RD),
   .SFR_RDATA(SFR_RDATA),
   .TIMEBASE_RUN(TIMEBASE_RUN),
   .TIMEBASE_TICK(TIMEBASE_TICK),
   .ARRAY_IRQ_ENABLE(ARRAY_IRQ_ENABLE),
   .CHANNEL_PIN_OUT(CHANNEL_PIN_OUT),
   .CHANNEL_PIN_OE(CHANNEL_PIN_OE),
   .TIMEBASE_CLEAR(TIMEBASE_CLEAR),
   .IRQ_REQUEST(IRQ_REQUEST)
);

// *** tb/sfr_host.sv ***
`timescale 1ns/1ps
module sfr_host (
   input wire logic clk,
   input wire capture_compare_pkg::byte_type rdata,
   output logic [7:0] addr,
   output capture_compare_pkg::byte_type wdata,
   output logic wr,
   output logic rd
);
   import capture_compare_pkg::*;
   initial begin
      addr = 8'h00;
      wdata = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
   end
   // One-cycle strobes; idle bus shows inverted values so stale data never looks valid
   task automatic put(input logic [7:0] a, input byte_type d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      addr <= ~a;
      wdata <= ~d;
   endtask
   // Read data lands on the same edge that samples the strobe
   task automatic get(input logic [7:0] a, output byte_type d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      addr <= ~a;
      #1 d = rdata;
   endtask
endmodule

// *** tb/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
   import capture_compare_pkg::*;
   logic clk_sys, rstn, run, tick, t0, cmp, aie, clr, irq, wr, rd;
   logic [3:0] pins, pout, oe;
   logic [7:0] addr;
   byte_type rdata, wdata, v;
   word_type tbv;
   logic [31:0] seed;
   int fail_count, checked, idx, shadow, flg, mpo;
   int ctl[4], dat[4];
   sfr_host host (.clk(clk_sys), .rdata(rdata), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));
   capture_compare_array uut (.CLK_SYS(clk_sys), .RSTN(rstn), .SFR_ADDR(addr),
      .SFR_WDATA(wdata), .SFR_WR(wr), .SFR_RD(rd), .SFR_RDATA(rdata), .TIMEBASE(tbv),
      .TIMEBASE_RUN(run), .TIMEBASE_TICK(tick), .TIMER0_OVERFLOW(t0),
      .COMPARATOR_CHANGE(cmp), .ARRAY_IRQ_ENABLE(aie), .CHANNEL_PIN_IN(pins),
      .CHANNEL_PIN_OUT(pout), .CHANNEL_PIN_OE(oe), .TIMEBASE_CLEAR(clr), .IRQ_REQUEST(irq));
   function automatic int rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return int'(seed);
   endfunction
   task automatic chk(string n, logic [15:0] s, logic [15:0] e);
      checked++;
      if (s !== e) begin
         fail_count++;
         $display("unexpected %s expected %h seen %h", n, e, s);
      end
   endtask
   // Bus write plus model update
   task automatic w(int a, int d);
      host.put(8'(a), 8'(d));
      case (a)
         ADDR_INDEX: idx = d & 3;
         ADDR_DATA_HIGH: shadow = d & 8'hFF;
         ADDR_DATA_LOW: if (ctl[idx][3]) dat[idx] = shadow << 8 | d & 8'hFF;
         ADDR_CONTROL: ctl[idx] = d & CTRL_WRITE_MASK;
         ADDR_FLAGS: flg = d & 4'hF;
         default: ;
      endcase
   endtask
   task automatic r(int a);
      int e;
      case (a)
         ADDR_INDEX: e = idx;
         ADDR_DATA_HIGH: e = dat[idx] >> 8;
         ADDR_DATA_LOW: e = dat[idx] & 8'hFF;
         ADDR_CONTROL: e = ctl[idx];
         ADDR_FLAGS: e = flg;
         default: e = 0;
      endcase
      host.get(8'(a), v);
      chk("register read", {8'h00, v}, 16'(e));
   endtask
   // One cycle of timer and event inputs, then outputs against the model
   task automatic ev(int tv, int ru, int tk, int pn, int ov, int cc);
      int m, hit, c, en, om;
      logic [3:0] old;
      old = pins;
      tv &= 16'hFFFF;
      {c, en, om} = '0;
      @(posedge clk_sys);
      {tbv, run, tick, pins, t0, cmp} <= {16'(tv), 1'(ru), 1'(tk), 4'(pn), 1'(ov), 1'(cc)};
      for (int k = 0; k < 4; k++) begin
         m = ctl[k] & 7;
         hit = m == 1 && old[k] && !pn[k] || m == 2 && !old[k] && pn[k] || m == 3 && old[k] != pn[k];
         en |= ctl[k][7] << k;
         om |= ctl[k][3] << k;
         if (ctl[k][3]) begin
            if (ru && tk && dat[k] == tv) begin
               flg |= 1 << k;
               mpo ^= (ctl[k] & 1) << k;
               c |= ctl[k][4];
            end
         end else if (hit || ru && (m == 4 && ov || m == 5 && cc)) begin
            flg |= 1 << k;
            if (ru) begin
               dat[k] = tv;
               c |= ctl[k][4];
            end
         end
      end
      @(posedge clk_sys);
      {tick, t0, cmp} <= 3'h0;
      #1;
      chk("timer clear", 16'(clr), 16'(c));
      chk("pin out", 16'(pout), 16'(mpo));
      chk("pin enable", 16'(oe), 16'(om));
      chk("irq", 16'(irq), 16'(aie && (flg & en) != 0));
   endtask
   task automatic summarize();
      if (fail_count == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   // Run needs a few hundred cycles; the limit leaves a wide margin
   initial begin
      #200000;
      fail_count++;
      summarize();
   end
   initial begin
      {rstn, run, tick, t0, cmp, tbv, pins, aie} = '0;
      {fail_count, checked, idx, shadow, flg, mpo} = '0;
      seed = 32'h0000A77F;
      ctl = '{default: 0};
      dat = '{default: 0};
      repeat (12) @(posedge clk_sys);
      rstn <= 1'b1;
      aie <= 1'b1;
      for (int a = 8'hD0; a < 8'hD7; a++) r(a);
      // Capture-mode low write ignored, then compare setup; channel C reuses the shadow
      for (int c = 0; c < 4; c++) begin
         w(ADDR_INDEX, c | 8'hFC);
         w(ADDR_DATA_HIGH, rnd());
         w(ADDR_DATA_LOW, rnd());
         w(ADDR_CONTROL, 8'hE9 | (c & 1) << 4);
         if (c != 2) w(ADDR_DATA_HIGH, rnd());
         w(ADDR_DATA_LOW, rnd());
         for (int a = ADDR_INDEX; a <= ADDR_FLAGS; a++) r(a);
      end
      // Matches only with timer running and on a tick
      for (int c = 0; c < 4; c++) begin
         ev(dat[c], 0, 1, 0, 0, 0);
         ev(dat[c], 1, 0, 0, 0, 0);
         ev(dat[c], 1, 1, 0, 0, 0);
         ev(dat[c], 1, 0, 0, 0, 0);
      end
      // Every capture source under random events
      for (int m = 1; m < 6; m++) begin
         w(ADDR_INDEX, m & 3);
         w(ADDR_CONTROL, 8'h90 | m);
         w(ADDR_FLAGS, 0);
         repeat (8) begin
            @(posedge clk_sys);
            aie <= 1'(rnd());
            ev(rnd(), rnd() & 1, rnd() & 1, rnd(), rnd() & 1, rnd() & 1);
         end
         r(ADDR_DATA_LOW);
         r(ADDR_DATA_HIGH);
         r(ADDR_FLAGS);
      end
      summarize();
   end
endmodule

// *** verilog/capture_compare_array.sv ***
`timescale 1ns/1ps
module capture_compare_array (
   input wire logic CLK_SYS,
   input wire logic RSTN,
   input wire logic [7:0] SFR_ADDR,
   input wire capture_compare_pkg::byte_type SFR_WDATA,
   input wire logic SFR_WR,
   input wire logic SFR_RD,
   output capture_compare_pkg::byte_type SFR_RDATA,
   input wire capture_compare_pkg::word_type TIMEBASE,
   input wire logic TIMEBASE_RUN,
   input wire logic TIMEBASE_TICK,
   input wire logic TIMER0_OVERFLOW,
   input wire logic COMPARATOR_CHANGE,
   input wire logic ARRAY_IRQ_ENABLE,
   input wire logic [3:0] CHANNEL_PIN_IN,
   output logic [3:0] CHANNEL_PIN_OUT,
   output logic [3:0] CHANNEL_PIN_OE,
   output logic TIMEBASE_CLEAR,
   output logic IRQ_REQUEST
);
   import capture_compare_pkg::*;

   typedef struct packed {
      logic [1:0] index;
      byte_type shadow;
      byte_type [CHANNELS-1:0] ctrl;
      word_type [CHANNELS-1:0] data;
      logic [CHANNELS-1:0] flags;
      logic [CHANNELS-1:0] pin_prev;
      logic [CHANNELS-1:0] pin_out;
      byte_type rdata;
      logic irq;
      logic clear;
   } array_state_type;

   localparam array_state_type STATE_RESET = '{
      index: INDEX_RESET,
      shadow: SHADOW_RESET,
      ctrl: {CHANNELS{CTRL_RESET}},
      data: {CHANNELS{DATA_RESET}},
      flags: '0,
      pin_prev: '0,
      pin_out: '0,
      rdata: BYTE_ZERO,
      irq: 1'b0,
      clear: 1'b0
   };

   array_state_type state_q;
   array_state_type state_d;
   logic [CHANNELS-1:0] irq_en;

   event_link_if link ();

   // Hand channel state to the decoder
   always_comb begin
      link.ctrl = state_q.ctrl;
      link.data = state_q.data;
      link.pin_now = CHANNEL_PIN_IN;
      link.pin_prev = state_q.pin_prev;
      link.timebase = TIMEBASE;
      link.run = TIMEBASE_RUN;
      link.tick = TIMEBASE_TICK;
      link.t0_ovf = TIMER0_OVERFLOW;
      link.comp_change = COMPARATOR_CHANGE;
   end

   channel_event_decode decoder (
      .link(link)
   );

   // Per-channel interrupt enables pulled from control bytes
   genvar g;
   generate
      for (g = 0; g < CHANNELS; g++) begin : g_ien
         assign irq_en[g] = state_q.ctrl[g][CTRL_IRQ_EN_BIT];
      end
   endgenerate

   // Next-state logic: bus access first, hardware events after so they win
   always_comb begin
      logic [1:0] sel;
      logic [CHANNELS-1:0] set_flag;
      logic [CHANNELS-1:0] clear_req;
      sel = state_q.index;
      set_flag = '0;
      clear_req = '0;
      state_d = state_q;
      state_d.clear = 1'b0;
      state_d.pin_prev = CHANNEL_PIN_IN;

      // Windowed writes reach only the indexed channel
      if (SFR_WR) begin
         unique case (SFR_ADDR)
            ADDR_INDEX: state_d.index = SFR_WDATA[1:0];
            ADDR_DATA_HIGH: state_d.shadow = SFR_WDATA;
            ADDR_DATA_LOW: begin
               // Capturing channels refuse software data
               if (state_q.ctrl[sel][CTRL_COMPARE_BIT]) begin
                  state_d.data[sel] = {state_q.shadow, SFR_WDATA};
               end
            end
            ADDR_CONTROL: state_d.ctrl[sel] = SFR_WDATA & CTRL_WRITE_MASK;
            ADDR_FLAGS: state_d.flags = SFR_WDATA[CHANNELS-1:0];
            default: ;
         endcase
      end

      // Channel events; a capture copy beats any write in the same cycle
      for (int i = 0; i < CHANNELS; i++) begin
         if (link.capture_hit[i]) begin
            state_d.data[i] = TIMEBASE;
         end
         set_flag[i] = link.capture_hit[i] | link.external_hit[i]
            | link.match_hit[i];
         clear_req[i] = (link.capture_hit[i] | link.match_hit[i])
            & state_q.ctrl[i][CTRL_CLEAR_BIT];
         if (link.match_hit[i] & state_q.ctrl[i][CTRL_TOGGLE_BIT]) begin
            state_d.pin_out[i] = ~state_q.pin_out[i];
         end
      end

      // Set wins over a software clear in the same cycle
      state_d.flags = state_d.flags | set_flag;
      state_d.clear = |clear_req;

      // Interrupt follows the flags in the same cycle they are set
      state_d.irq = ARRAY_IRQ_ENABLE & |(state_d.flags & irq_en);

      // Read data is captured on the strobe and held until the next read
      if (SFR_RD) begin
         unique case (SFR_ADDR)
            ADDR_INDEX: state_d.rdata = {6'h00, state_q.index};
            ADDR_DATA_HIGH: state_d.rdata = state_q.data[sel][15:8];
            ADDR_DATA_LOW: state_d.rdata = state_q.data[sel][7:0];
            ADDR_CONTROL: state_d.rdata = state_q.ctrl[sel];
            ADDR_FLAGS: state_d.rdata = {4'h0, state_q.flags};
            default: state_d.rdata = BYTE_ZERO;
         endcase
      end
   end

   // Single state register; reset leaves all channels capturing
   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         state_q <= STATE_RESET;
      end else begin
         state_q <= state_d;
      end
   end

   // Outputs straight from the state register
   assign SFR_RDATA = state_q.rdata;
   assign CHANNEL_PIN_OUT = state_q.pin_out;
   assign TIMEBASE_CLEAR = state_q.clear;
   assign IRQ_REQUEST = state_q.irq;

   // Pin is driven while its channel compares
   generate
      for (g = 0; g < CHANNELS; g++) begin : g_oe
         assign CHANNEL_PIN_OE[g] = state_q.ctrl[g][CTRL_COMPARE_BIT];
      end
   endgenerate

endmodule

// *** verilog/capture_compare_pkg.sv ***
package capture_compare_pkg;

   localparam int CHANNELS = 4;

   // Special function register addresses
   localparam logic [7:0] ADDR_INDEX = 8'hD1;
   localparam logic [7:0] ADDR_DATA_HIGH = 8'hD2;
   localparam logic [7:0] ADDR_DATA_LOW = 8'hD3;
   localparam logic [7:0] ADDR_CONTROL = 8'hD4;
   localparam logic [7:0] ADDR_FLAGS = 8'hD5;

   // Control byte layout
   localparam int CTRL_IRQ_EN_BIT = 7;
   localparam int CTRL_CLEAR_BIT = 4;
   localparam int CTRL_COMPARE_BIT = 3;
   localparam int CTRL_TOGGLE_BIT = 0;
   localparam int MODE_MSB = 2;
   // Direction bit 6 and bit 5 are not stored and read zero
   localparam logic [7:0] CTRL_WRITE_MASK = 8'h9F;

   // Reset values
   localparam logic [1:0] INDEX_RESET = 2'h0;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [15:0] DATA_RESET = 16'h0000;
   localparam logic [7:0] SHADOW_RESET = 8'h00;
   localparam logic [7:0] BYTE_ZERO = 8'h00;

   typedef logic [7:0] byte_type;
   typedef logic [15:0] word_type;

   // Capture event selection codes
   typedef enum logic [2:0] {
      EV_OFF,
      EV_FALL,
      EV_RISE,
      EV_EITHER,
      EV_T0_OVF,
      EV_COMPARATOR
   } event_sel_type;

endpackage

// *** verilog/channel_event_decode.sv ***
`timescale 1ns/1ps
module channel_event_decode (
   event_link_if.decode link
);
   import capture_compare_pkg::*;

   genvar i;
   generate
      for (i = 0; i < CHANNELS; i++) begin : g_chan
         logic fall;
         logic rise;
         logic pin_evt;
         logic any_evt;
         logic compare_mode;
         event_sel_type sel;

         // Per-channel source decode
         always_comb begin
            fall = link.pin_prev[i] & ~link.pin_now[i];
            rise = ~link.pin_prev[i] & link.pin_now[i];
            compare_mode = link.ctrl[i][CTRL_COMPARE_BIT];
            sel = event_sel_type'(link.ctrl[i][MODE_MSB:0]);
            pin_evt = 1'b0;
            any_evt = 1'b0;
            unique case (sel)
               EV_OFF: ;
               EV_FALL: pin_evt = fall;
               EV_RISE: pin_evt = rise;
               EV_EITHER: pin_evt = fall | rise;
               EV_T0_OVF: any_evt = link.t0_ovf;
               EV_COMPARATOR: any_evt = link.comp_change;
               default: ;
            endcase
            any_evt = any_evt | pin_evt;
            // Copies only while the timer runs
            link.capture_hit[i] = ~compare_mode & link.run & any_evt;
            // Stopped timer: pin events still flag, no copy
            link.external_hit[i] = ~compare_mode & ~link.run & pin_evt;
            // One look per count update avoids repeated hits on a held count
            link.match_hit[i] = compare_mode & link.run & link.tick
               & (link.timebase == link.data[i]);
         end
      end
   endgenerate

endmodule

// *** verilog/event_link_if.sv ***
`timescale 1ns/1ps
// Carries channel state to the event decoder and its verdicts back
interface event_link_if;
   import capture_compare_pkg::*;
   byte_type [CHANNELS-1:0] ctrl;
   word_type [CHANNELS-1:0] data;
   logic [CHANNELS-1:0] pin_now;
   logic [CHANNELS-1:0] pin_prev;
   word_type timebase;
   logic run;
   logic tick;
   logic t0_ovf;
   logic comp_change;
   logic [CHANNELS-1:0] capture_hit;
   logic [CHANNELS-1:0] external_hit;
   logic [CHANNELS-1:0] match_hit;

   modport array (output ctrl, data, pin_now, pin_prev, timebase, run, tick, t0_ovf,
      comp_change, input capture_hit, external_hit, match_hit);
   modport decode (input ctrl, data, pin_now, pin_prev, timebase, run, tick, t0_ovf,
      comp_change, output capture_hit, external_hit, match_hit);
endinterface
